// *** pnp_buf.sv ***
// Shared constants of the parallel programming port controller and its two-entry read buffer.
`timescale 1ns/100ps
`default_nettype none

package pnp_pkg;
	localparam int CLK_NS         = 50;
	// Timing figures, in nanoseconds, and the synchroniser depth in stages.
	localparam int PULSE_NS       = 250;
	localparam int SETUP_NS       = 67;
	localparam int HOLD_NS        = 67;
	localparam int WLRL_MAX_NS    = 1000;
	localparam int OLDV_MAX_NS    = 250;
	localparam int OHDZ_MAX_NS    = 250;
	localparam int WLRH_CE_MAX_NS = 9000000;
	localparam int SYNC_STAGES    = 2;
	// Least times and the two output enable delays round up; the write-to-ready and timeout limits round down.
	localparam int PULSE_CYC      = (PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SETUP_CYC      = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC       = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int WLRL_CYC       = WLRL_MAX_NS / CLK_NS;
	localparam int OLDV_CYC       = (OLDV_MAX_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
	localparam int OHDZ_CYC       = (OHDZ_MAX_NS + CLK_NS - 1) / CLK_NS;
	localparam int TIMEOUT_CYC    = WLRH_CE_MAX_NS / CLK_NS;
	localparam int CNT_W          = 18;
	localparam int DATA_W         = 8;
	localparam int BUF_DEPTH      = 2;
	// Action select codes for the load strobe.
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD  = 2'h2;
	localparam logic [1:0] ACT_IDLE = 2'h3;
	// Device command codes, for the user's reference.
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
	localparam logic [7:0] CMD_WR_FUSE    = 8'h40;
	localparam logic [7:0] CMD_WR_LOCK    = 8'h20;
	localparam logic [7:0] CMD_WR_FLASH   = 8'h10;
	localparam logic [7:0] CMD_WR_EEPROM  = 8'h11;
	localparam logic [7:0] CMD_RD_SIG     = 8'h08;
	localparam logic [7:0] CMD_RD_FUSE    = 8'h04;
	localparam logic [7:0] CMD_RD_FLASH   = 8'h02;
	localparam logic [7:0] CMD_RD_EEPROM  = 8'h03;
	localparam logic [7:0] CMD_NOP        = 8'h00;

	typedef enum logic [2:0] {
		OP_CMD   = 3'h0,
		OP_ADDR  = 3'h1,
		OP_DATA  = 3'h2,
		OP_LATCH = 3'h3,
		OP_WRITE = 3'h4,
		OP_READ  = 3'h5
	} pnp_op_e;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_SETUP = 3'h1,
		ST_PULSE = 3'h2,
		ST_HOLD  = 3'h3,
		ST_WLRL  = 3'h4,
		ST_RDY   = 3'h5,
		ST_RD    = 3'h6,
		ST_TURN  = 3'h7
	} pnp_state_e;
endpackage

////////////////////////////////////////////////////////////////////////////////

module pnp_buf
	import pnp_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	input  wire logic              in_valid_i,
	output logic                   in_ready_o,
	input  wire logic [DATA_W-1:0] in_data_i,
	output logic                   out_valid_o,
	input  wire logic              out_ready_i,
	output logic [DATA_W-1:0]      out_data_o
);
	logic [DATA_W-1:0] mem_q [BUF_DEPTH];
	logic [DATA_W-1:0] mem_d [BUF_DEPTH];
	logic              wr_ptr_q, wr_ptr_d;
	logic              rd_ptr_q, rd_ptr_d;
	logic [1:0]        count_q, count_d;
	logic              push;
	logic              pop;

	always_comb begin
		push     = in_valid_i && (count_q != 2'(BUF_DEPTH));
		pop      = out_ready_i && (count_q != 2'h0);
		mem_d    = mem_q;
		wr_ptr_d = wr_ptr_q;
		rd_ptr_d = rd_ptr_q;
		count_d  = count_q;
		if (push) begin
			mem_d[wr_ptr_q] = in_data_i;
			wr_ptr_d        = ~wr_ptr_q;
		end
		if (pop) begin
			rd_ptr_d = ~rd_ptr_q;
		end
		if (push && !pop) begin
			count_d = count_q + 2'h1;
		end else if (pop && !push) begin
			count_d = count_q - 2'h1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < BUF_DEPTH; i++) begin
				mem_q[i] <= '0;
			end
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q  <= 2'h0;
		end else begin
			mem_q    <= mem_d;
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			count_q  <= count_d;
		end
	end

	assign in_ready_o  = (count_q != 2'(BUF_DEPTH));
	assign out_valid_o = (count_q != 2'h0);
	assign out_data_o  = mem_q[rd_ptr_q];
endmodule // pnp_buf

`default_nettype wire

// *** pnp_ctrl.sv ***
// Programmer that drives the device's parallel programming pins from a user request port.
// Operation
// - High address byte reload may be skipped inside one 256 window.
// - Command load: action 10, primary select 0, code on data, load strobe.
// - Chip erase starts on write-low pulse; wait ready before next command.
// - Action 00 loads address byte; primary select picks low or high.
// - Action 01 loads data byte; primary select picks low or high.
// - Page latch pulse with primary select 1 stores word in page buffer.
// - Write-low pulse programs flash page; wait ready before next page.
// - Loading command 0000 0000 ends page programming as no operation.
// - EEPROM page written by write-low pulse with select 0, then wait ready.
// - Fuse write: code 0100 0000, data byte, byte selects pick fuse byte.
`timescale 1ns/100ps
`default_nettype none

module pnp_ctrl
	import pnp_pkg::*;
#(
	parameter int TIMEOUT = TIMEOUT_CYC
) (
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	// User request port.
	input  wire logic              req_valid_i,
	output logic                   req_ready_o,
	input  wire logic [2:0]        req_op_i,
	input  wire logic [DATA_W-1:0] req_data_i,
	input  wire logic [1:0]        req_sel_i,
	output logic                   timeout_o,
	// Read data toward the user.
	output logic                   rd_valid_o,
	input  wire logic              rd_ready_i,
	output logic [DATA_W-1:0]      rd_data_o,
	// Device pins.
	output logic                   action_select_hi_o,
	output logic                   action_select_lo_o,
	output logic                   byte_select_primary_o,
	output logic                   byte_select_secondary_o,
	output logic                   page_latch_strobe_o,
	output logic                   load_strobe_clock_o,
	output logic                   wr_b_o,
	output logic                   oe_b_o,
	input  wire logic              ready_not_busy_i,
	input  wire logic [DATA_W-1:0] data_i,
	output logic [DATA_W-1:0]      data_o,
	output logic                   data_oe_b_o
);
	typedef logic [CNT_W-1:0] pnp_cnt_t;

	pnp_state_e        state_q, state_d;
	pnp_op_e           op_q, op_d;
	pnp_cnt_t          cnt_q, cnt_d;
	logic [1:0]        act_q, act_d;
	logic              sel_pri_q, sel_pri_d;
	logic              sel_sec_q, sel_sec_d;
	logic              page_q, page_d;
	logic              xtal_q, xtal_d;
	logic              wr_b_q, wr_b_d;
	logic              oe_b_q, oe_b_d;
	logic [DATA_W-1:0] dout_q, dout_d;
	logic              dout_oe_b_q, dout_oe_b_d;
	logic              req_ready_q, req_ready_d;
	logic              timeout_q, timeout_d;
	logic [DATA_W-1:0] hi_q, hi_d;
	logic              hi_vld_q, hi_vld_d;
	logic              push;
	logic              buf_in_ready;
	// Synchronisers for the device's inputs.
	logic              rdy_s1_q, rdy_s2_q;
	logic [DATA_W-1:0] din_s1_q, din_s2_q;

	////////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdy_s1_q <= 1'b0;
			rdy_s2_q <= 1'b0;
			din_s1_q <= '0;
			din_s2_q <= '0;
		end else begin
			rdy_s1_q <= ready_not_busy_i;
			rdy_s2_q <= rdy_s1_q;
			din_s1_q <= data_i;
			din_s2_q <= din_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		state_d     = state_q;
		op_d        = op_q;
		cnt_d       = cnt_q;
		act_d       = act_q;
		sel_pri_d   = sel_pri_q;
		sel_sec_d   = sel_sec_q;
		page_d      = page_q;
		xtal_d      = xtal_q;
		wr_b_d      = wr_b_q;
		oe_b_d      = oe_b_q;
		dout_d      = dout_q;
		dout_oe_b_d = dout_oe_b_q;
		timeout_d   = timeout_q;
		hi_d        = hi_q;
		hi_vld_d    = hi_vld_q;
		push        = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (req_valid_i && req_ready_q) begin
					op_d      = pnp_op_e'(req_op_i);
					timeout_d = 1'b0;
					cnt_d     = pnp_cnt_t'(SETUP_CYC - 1);
					state_d   = ST_SETUP;
					sel_pri_d = req_sel_i[0];
					sel_sec_d = req_sel_i[1];
					case (pnp_op_e'(req_op_i))
						OP_CMD: begin
							act_d       = ACT_CMD;
							sel_pri_d   = 1'b0;
							sel_sec_d   = 1'b0;
							dout_d      = req_data_i;
							dout_oe_b_d = 1'b0;
						end
						OP_ADDR: begin
							// A repeated high byte is dropped; the device still holds it.
							if (req_sel_i[0] && hi_vld_q && (hi_q == req_data_i)) begin
								state_d = ST_IDLE;
							end else begin
								act_d       = ACT_ADDR;
								sel_sec_d   = 1'b0;
								dout_d      = req_data_i;
								dout_oe_b_d = 1'b0;
								if (req_sel_i[0]) begin
									hi_d     = req_data_i;
									hi_vld_d = 1'b1;
								end
							end
						end
						OP_DATA: begin
							act_d       = ACT_DATA;
							sel_sec_d   = 1'b0;
							dout_d      = req_data_i;
							dout_oe_b_d = 1'b0;
						end
						OP_LATCH: begin
							act_d     = ACT_IDLE;
							sel_pri_d = 1'b1;
							sel_sec_d = 1'b0;
						end
						OP_WRITE: begin
							act_d = ACT_IDLE;
						end
						OP_READ: begin
							act_d = ACT_IDLE;
						end
						default: begin
							state_d = ST_IDLE;
						end
					endcase
				end
			end
			ST_SETUP: begin
				if (cnt_q == '0) begin
					cnt_d   = pnp_cnt_t'(PULSE_CYC - 1);
					state_d = ST_PULSE;
					case (op_q)
						OP_CMD, OP_ADDR, OP_DATA: begin
							xtal_d = 1'b1;
						end
						OP_LATCH: begin
							page_d = 1'b1;
						end
						OP_WRITE: begin
							wr_b_d = 1'b0;
						end
						OP_READ: begin
							oe_b_d  = 1'b0;
							cnt_d   = pnp_cnt_t'(OLDV_CYC - 1);
							state_d = ST_RD;
						end
						default: begin
							state_d = ST_IDLE;
						end
					endcase
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			ST_PULSE: begin
				if (cnt_q == '0) begin
					xtal_d = 1'b0;
					page_d = 1'b0;
					wr_b_d = 1'b1;
					if (op_q == OP_WRITE) begin
						cnt_d   = pnp_cnt_t'(WLRL_CYC - 1);
						state_d = ST_WLRL;
					end else begin
						cnt_d   = pnp_cnt_t'(HOLD_CYC - 1);
						state_d = ST_HOLD;
					end
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			ST_HOLD: begin
				if (cnt_q == '0) begin
					dout_oe_b_d = 1'b1;
					act_d       = ACT_IDLE;
					state_d     = ST_IDLE;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			ST_WLRL: begin
				// Ready is not trusted until the device has had its longest time to drop it.
				if (cnt_q == '0) begin
					cnt_d   = pnp_cnt_t'(TIMEOUT - 1);
					state_d = ST_RDY;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			ST_RDY: begin
				if (rdy_s2_q) begin
					state_d = ST_IDLE;
				end else if (cnt_q == '0) begin
					timeout_d = 1'b1;
					state_d   = ST_IDLE;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			ST_RD: begin
				// A full buffer holds output enable low, so no read byte is lost.
				if (cnt_q != '0) begin
					cnt_d = cnt_q - 1'b1;
				end else if (buf_in_ready) begin
					push    = 1'b1;
					oe_b_d  = 1'b1;
					cnt_d   = pnp_cnt_t'(OHDZ_CYC - 1);
					state_d = ST_TURN;
				end
			end
			ST_TURN: begin
				// The bus stays released until the device has surely stopped driving.
				if (cnt_q == '0) begin
					state_d = ST_IDLE;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		req_ready_d = (state_d == ST_IDLE);
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q     <= ST_IDLE;
			op_q        <= OP_CMD;
			cnt_q       <= '0;
			act_q       <= ACT_IDLE;
			sel_pri_q   <= 1'b0;
			sel_sec_q   <= 1'b0;
			page_q      <= 1'b0;
			xtal_q      <= 1'b0;
			wr_b_q      <= 1'b1;
			oe_b_q      <= 1'b1;
			dout_q      <= '0;
			dout_oe_b_q <= 1'b1;
			req_ready_q <= 1'b0;
			timeout_q   <= 1'b0;
			hi_q        <= '0;
			hi_vld_q    <= 1'b0;
		end else begin
			state_q     <= state_d;
			op_q        <= op_d;
			cnt_q       <= cnt_d;
			act_q       <= act_d;
			sel_pri_q   <= sel_pri_d;
			sel_sec_q   <= sel_sec_d;
			page_q      <= page_d;
			xtal_q      <= xtal_d;
			wr_b_q      <= wr_b_d;
			oe_b_q      <= oe_b_d;
			dout_q      <= dout_d;
			dout_oe_b_q <= dout_oe_b_d;
			req_ready_q <= req_ready_d;
			timeout_q   <= timeout_d;
			hi_q        <= hi_d;
			hi_vld_q    <= hi_vld_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	pnp_buf u_buf (
		.clk_i       (clk_i),
		.rst_b_i     (rst_b_i),
		.in_valid_i  (push),
		.in_ready_o  (buf_in_ready),
		.in_data_i   (din_s2_q),
		.out_valid_o (rd_valid_o),
		.out_ready_i (rd_ready_i),
		.out_data_o  (rd_data_o)
	);

	assign req_ready_o             = req_ready_q;
	assign timeout_o               = timeout_q;
	assign action_select_hi_o      = act_q[1];
	assign action_select_lo_o      = act_q[0];
	assign byte_select_primary_o   = sel_pri_q;
	assign byte_select_secondary_o = sel_sec_q;
	assign page_latch_strobe_o     = page_q;
	assign load_strobe_clock_o     = xtal_q;
	assign wr_b_o                  = wr_b_q;
	assign oe_b_o                  = oe_b_q;
	assign data_o                  = dout_q;
	assign data_oe_b_o             = dout_oe_b_q;
endmodule // pnp_ctrl

`default_nettype wire

// *** pnp_dev.sv ***
// Behavioural model of the device behind the parallel programming pins.
`timescale 1ns/100ps
`default_nettype none

module pnp_dev #(
	parameter int              BUSY_NS = 5000,
	parameter int              KEEP    = 3,
	// Identification and calibration values are arbitrary.
	parameter logic [2:0][7:0] SIG     = {8'h3C, 8'h5A, 8'hA5},
	parameter logic [7:0]      CAL     = 8'h77
) (
	input  wire logic       action_select_hi_i,
	input  wire logic       action_select_lo_i,
	input  wire logic       byte_select_primary_i,
	input  wire logic       byte_select_secondary_i,
	input  wire logic       page_latch_strobe_i,
	input  wire logic       load_strobe_clock_i,
	input  wire logic       wr_b_i,
	input  wire logic       oe_b_i,
	input  wire logic [7:0] data_i,
	output logic            ready_not_busy_o,
	output logic [7:0]      data_o,
	output logic            data_en_o
);
	logic [7:0]  cmd, al, ah, dl, dh;
	logic [7:0]  lk = 8'hFF;
	logic [7:0]  fu [3] = '{8'hFF, 8'hFF, 8'hFF};
	logic [15:0] pb [int];
	logic [15:0] fl [int];
	logic [7:0]  eb [int];
	logic [7:0]  ee [int];
	wire  [1:0]  act = {action_select_hi_i, action_select_lo_i};
	wire         sp = byte_select_primary_i;
	wire  [1:0]  spair = {byte_select_secondary_i, sp};
	initial ready_not_busy_o = 1'b1;
	initial data_en_o = 1'b0;

	always @(posedge load_strobe_clock_i) begin
		case (act)
			2'h2: cmd = data_i;
			2'h0: if (sp) ah = data_i; else al = data_i;
			2'h1: if (sp) dh = data_i; else dl = data_i;
			default: ;
		endcase
	end

	always @(posedge page_latch_strobe_i) begin
		if (sp) begin
			pb[al[5:0]] = {dh, dl};
			eb[al[1:0]] = dl;
		end
	end

	always @(negedge wr_b_i) begin
		case (cmd)
			8'h80: if (fu[1][KEEP]) ee.delete();
			8'h10: foreach (pb[i]) fl[{ah, al[7:6], i[5:0]}] = pb[i];
			8'h11: if (!sp) foreach (eb[i]) ee[{ah[0], al[7:2], i[1:0]}] = eb[i];
			8'h40: fu[spair[1] ? 2 : sp] = dl;
			8'h20: lk = lk & {2'h3, lk[1:0] == 2'h0 ? 4'hF : dl[5:2], dl[1:0]};
			default: ;
		endcase
		pb.delete();
		eb.delete();
		#200 ready_not_busy_o = 1'b0;
		#(BUSY_NS);
		// Flash and locks are cleared only once the busy time is over.
		if (cmd == 8'h80) begin
			fl.delete();
			lk = 8'hFF;
		end
		ready_not_busy_o = 1'b1;
	end

	function automatic logic [7:0] rd();
		logic [15:0] w;
		w = fl.exists({ah, al}) ? fl[{ah, al}] : 16'hFFFF;
		case (cmd)
			8'h02: return sp ? w[15:8] : w[7:0];
			8'h03: return ee.exists({ah[0], al}) ? ee[{ah[0], al}] : 8'hFF;
			8'h04: return spair == 2'h1 ? lk : fu[spair == 2'h3 ? 1 : spair[1] ? 2 : 0];
			8'h08: return sp ? CAL : SIG[al[1:0]];
			default: return 8'h00;
		endcase
	endfunction

	always @(negedge oe_b_i) begin
		data_o = rd();
		data_en_o = 1'b1;
	end
	always @(posedge oe_b_i) data_en_o = 1'b0;
endmodule // pnp_dev

`default_nettype wire

// *** pnp_ctrl_chk.sv ***
// Pin timing checker of the programming port controller.
`timescale 1ns/100ps
`default_nettype none

module pnp_ctrl_chk
	import pnp_pkg::*;
(
	input wire logic              clk_i,
	input wire logic              rst_b_i,
	input wire logic              req_ready_o,
	input wire logic              timeout_o,
	input wire logic              rd_valid_o,
	input wire logic              action_select_hi_o,
	input wire logic              action_select_lo_o,
	input wire logic              byte_select_primary_o,
	input wire logic              byte_select_secondary_o,
	input wire logic              page_latch_strobe_o,
	input wire logic              load_strobe_clock_o,
	input wire logic              wr_b_o,
	input wire logic              oe_b_o,
	input wire logic              ready_not_busy_i,
	input wire logic [DATA_W-1:0] data_o,
	input wire logic              data_oe_b_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	wire [1:0] act = {action_select_hi_o, action_select_lo_o};
	wire       ls = load_strobe_clock_o;
	wire       pl = page_latch_strobe_o;

	property p_idle;
		req_ready_o |-> act == ACT_IDLE && wr_b_o && oe_b_o && !ls && !pl && data_oe_b_o;
	endproperty
	a_idle: assert property (p_idle) else $error("pins not idle while ready");
	property p_ls;
		$rose(ls) |-> ls [*5] ##1 !ls;
	endproperty
	a_ls: assert property (p_ls) else $error("load strobe width wrong");
	property p_lsd;
		ls |-> !data_oe_b_o && oe_b_o && $stable(data_o) && $stable(act);
	endproperty
	a_lsd: assert property (p_lsd) else $error("bus moved during load strobe");
	property p_hold;
		$fell(ls) |-> (!data_oe_b_o && $stable(data_o) && $stable(act)) [*2];
	endproperty
	a_hold: assert property (p_hold) else $error("bus hold after load strobe short");
	property p_cmd;
		ls && act == ACT_CMD |-> !byte_select_primary_o;
	endproperty
	a_cmd: assert property (p_cmd) else $error("command load with high select");
	property p_wr;
		$fell(wr_b_o) |-> !wr_b_o [*5] ##1 wr_b_o;
	endproperty
	a_wr: assert property (p_wr) else $error("write strobe width wrong");
	property p_wsel;
		!wr_b_o |-> $stable(byte_select_primary_o) && $stable(byte_select_secondary_o);
	endproperty
	a_wsel: assert property (p_wsel) else $error("byte select moved during write");
	property p_pl;
		$rose(pl) |-> (pl && byte_select_primary_o) [*5] ##1 !pl;
	endproperty
	a_pl: assert property (p_pl) else $error("page latch pulse wrong");
	property p_bus;
		!oe_b_o |-> data_oe_b_o;
	endproperty
	a_bus: assert property (p_bus) else $error("bus driven against device");
	property p_rdy;
		$rose(req_ready_o) && !timeout_o |-> $past(ready_not_busy_i, 2);
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready before device ready");
	property p_rd;
		$fell(oe_b_o) |-> ##[1:40] rd_valid_o;
	endproperty
	a_rd: assert property (p_rd) else $error("read byte not delivered");
	c_wr: cover property ($fell(wr_b_o));
	c_pl: cover property ($rose(pl));
	c_rd: cover property ($rose(rd_valid_o));
endmodule // pnp_ctrl_chk

bind pnp_ctrl pnp_ctrl_chk i_pnp_ctrl_chk (.*);

`default_nettype wire

// *** pnp_ctrl_tb.sv ***
// Self-checking bench of the programming port controller with a device model.
`timescale 1ns/100ps
`default_nettype none

module pnp_ctrl_tb
	import pnp_pkg::*;
;
	// Identification and calibration values are arbitrary.
	localparam logic [2:0][7:0] SG  = {8'h3C, 8'h5A, 8'hA5};
	localparam logic [7:0]      CAL = 8'h77;
	logic        clk_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic        req_valid_i = 1'b0;
	logic        rd_ready_i = 1'b0;
	logic [2:0]  req_op_i = 3'h0;
	logic [7:0]  req_data_i = 8'h00;
	logic [1:0]  req_sel_i = 2'h0;
	logic        req_ready_o, timeout_o, rd_valid_o, action_select_hi_o, action_select_lo_o;
	logic        byte_select_primary_o, byte_select_secondary_o, page_latch_strobe_o;
	logic        load_strobe_clock_o, wr_b_o, oe_b_o, data_oe_b_o, ready_not_busy_i, de;
	logic [7:0]  rd_data_o, data_o, dv;
	// A released bus shows the inverse of the last byte, never a stale match.
	wire  [7:0]  data_i = !data_oe_b_o ? data_o : de ? dv : ~data_o;
	int          bad_count = 0;
	int          check_count = 0;
	int          cyc = 0;
	logic [7:0]  fv [3] = '{8'hE2, 8'hDF, 8'hFD};
	logic [1:0]  fs [3] = '{2'h0, 2'h1, 2'h2};
	logic [1:0]  fr [3] = '{2'h0, 2'h3, 2'h2};
	logic [15:0] wv [2] = '{16'h1234, 16'hBEEF};

	pnp_ctrl #(.TIMEOUT(400)) i_pnp_ctrl (.*);
	pnp_dev #(.SIG(SG), .CAL(CAL)) i_pnp_dev (
		.action_select_hi_i      (action_select_hi_o),
		.action_select_lo_i      (action_select_lo_o),
		.byte_select_primary_i   (byte_select_primary_o),
		.byte_select_secondary_i (byte_select_secondary_o),
		.page_latch_strobe_i     (page_latch_strobe_o),
		.load_strobe_clock_i     (load_strobe_clock_o),
		.wr_b_i                  (wr_b_o),
		.oe_b_i                  (oe_b_o),
		.data_i                  (data_i),
		.ready_not_busy_o        (ready_not_busy_i),
		.data_o                  (dv),
		.data_en_o               (de)
	);

	always #25 clk_i = ~clk_i;

	////////////////////////////////////////
	task automatic end_of_test();
		if (bad_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic op(input logic [2:0] o, input logic [7:0] d, input logic [1:0] b);
		req_op_i <= o;
		req_data_i <= d;
		req_sel_i <= b;
		req_valid_i <= 1'b1;
		do @(posedge clk_i); while (req_ready_o !== 1'b1);
		req_valid_i <= 1'b0;
		do @(posedge clk_i); while (req_ready_o !== 1'b1);
	endtask
	task automatic cm(input logic [7:0] c);
		op(OP_CMD, c, 2'h0);
	endtask
	task automatic pop(input logic [7:0] e);
		rd_ready_i <= 1'b1;
		do @(posedge clk_i); while (rd_valid_o !== 1'b1);
		chk("rd_data_o", e, rd_data_o);
		rd_ready_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [1:0] b, input logic [7:0] e);
		op(OP_READ, 8'h00, b);
		pop(e);
	endtask
	task automatic eew(input logic [7:0] d);
		cm(CMD_WR_EEPROM);
		op(OP_ADDR, 8'h01, 2'h1);
		op(OP_ADDR, 8'h25, 2'h0);
		op(OP_DATA, d, 2'h0);
		op(OP_LATCH, 8'h00, 2'h1);
		op(OP_WRITE, 8'h00, 2'h0);
	endtask
	task automatic eer(input logic [7:0] e);
		cm(CMD_RD_EEPROM);
		op(OP_ADDR, 8'h25, 2'h0);
		rd(2'h0, e);
	endtask
	task automatic erase();
		cm(CMD_CHIP_ERASE);
		op(OP_WRITE, 8'h00, 2'h0);
	endtask

	////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk_i);
		rst_b_i <= 1'b1;
		cm(CMD_WR_FUSE);
		for (int i = 0; i < 3; i++) begin
			op(OP_DATA, fv[i], 2'h0);
			op(OP_WRITE, 8'h00, fs[i]);
		end
		cm(CMD_RD_FUSE);
		for (int i = 0; i < 3; i++) rd(fr[i], fv[i]);
		cm(CMD_WR_FLASH);
		for (int i = 0; i < 2; i++) begin
			op(OP_ADDR, 8'(8'h40 + i), 2'h0);
			op(OP_DATA, wv[i][7:0], 2'h0);
			op(OP_DATA, wv[i][15:8], 2'h1);
			op(OP_LATCH, 8'h00, 2'h1);
		end
		op(OP_ADDR, 8'h03, 2'h1);
		op(OP_WRITE, 8'h00, 2'h0);
		cm(CMD_NOP);
		cm(CMD_RD_FLASH);
		op(OP_ADDR, 8'h03, 2'h1);
		for (int i = 0; i < 2; i++) begin
			op(OP_ADDR, 8'(8'h40 + i), 2'h0);
			rd(2'h0, wv[i][7:0]);
			rd(2'h1, wv[i][15:8]);
		end
		eew(8'h5C);
		eer(8'h5C);
		cm(CMD_WR_LOCK);
		op(OP_DATA, 8'hFC, 2'h0);
		op(OP_WRITE, 8'h00, 2'h0);
		op(OP_DATA, 8'hC3, 2'h0);
		op(OP_WRITE, 8'h00, 2'h0);
		cm(CMD_RD_FUSE);
		rd(2'h1, 8'hFC);
		erase();
		chk("timeout_o", 8'h00, {7'h00, timeout_o});
		cm(CMD_RD_FUSE);
		rd(2'h1, 8'hFF);
		rd(2'h0, fv[0]);
		eer(8'hFF);
		cm(CMD_RD_FLASH);
		op(OP_ADDR, 8'h03, 2'h1);
		op(OP_ADDR, 8'h40, 2'h0);
		rd(2'h0, 8'hFF);
		cm(CMD_WR_FUSE);
		op(OP_DATA, 8'hD7, 2'h0);
		op(OP_WRITE, 8'h00, 2'h1);
		eew(8'hA9);
		erase();
		eer(8'hA9);
		cm(CMD_RD_SIG);
		for (int i = 1; i < 3; i++) begin
			op(OP_ADDR, 8'(i), 2'h0);
			rd(2'h0, SG[i]);
		end
		// Two reads before any pop fill the read buffer to its depth.
		op(OP_ADDR, 8'h00, 2'h0);
		op(OP_READ, 8'h00, 2'h0);
		op(OP_READ, 8'h00, 2'h1);
		pop(SG[0]);
		pop(CAL);
		chk("rd_valid_o", 8'h00, {7'h00, rd_valid_o});
		end_of_test();
	end

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			bad_count++;
			end_of_test();
		end
	end
endmodule // pnp_ctrl_tb

`default_nettype wire
